// *** core/mbi_map.svh ***
// constants for the multiplexed processor bus interface
// assumes inclusion by the package and the design file only
`ifndef MBI_MAP_SVH
`define MBI_MAP_SVH
`define MBI_LOW_ADDR_W     4
`define MBI_BYTE_LANES     4
`define MBI_BURST_WORDS    3'h4
`define MBI_CFG_BOOT16_BIT 0
`define MBI_CFG_BOOT8_BIT  1
`define MBI_CFG_RSVD_BIT   2
`define MBI_CFG_HOLD_BIT   3
`define MBI_CFG_RESET      4'h0
`define MBI_STRB_IDLE      4'hF
`endif

// *** core/mbi_pkg.sv ***
// types for the multiplexed processor bus interface
// assumes mbi_map.svh sits beside it on the include path
`include "mbi_map.svh"
package mbi_pkg;
  typedef enum logic [1:0] {
    MBI_PORT32 = 2'h0,
    MBI_PORT16 = 2'h1,
    MBI_PORT8  = 2'h2
  } mbi_port_t;

  typedef enum logic [1:0] {
    MBI_SZ_BYTE = 2'h0,
    MBI_SZ_HALF = 2'h1,
    MBI_SZ_WORD = 2'h3
  } mbi_size_t;

  typedef enum logic [2:0] {
    MBI_IDLE  = 3'h0,
    MBI_ADDR  = 3'h1,
    MBI_TURN  = 3'h2,
    MBI_DATA  = 3'h3,
    MBI_HOLD  = 3'h4
  } mbi_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    mbi_size_t   size;
    mbi_port_t   port;
    logic        write;
    logic        burst;
    logic        miss;
    logic        instr;
  } mbi_req_t;

  typedef struct packed {
    logic        bootRom16;
    logic        bootRom8;
    logic        reserved_high_option;
    logic        extended_address_hold_option;
  } mbi_cfg_t;
endpackage

// *** core/mbi_bus_if.sv ***
// processor side of the multiplexed address/data bus
// assumes a core request port, a memory datum-ready strobe and pad logic for the shared lines
//
// Functional notes
// - one shared bus: address phase, then data
// - address phase drives address bits 31:4
// - byte strobes on low four lines, addr phase
// - strobes held inactive on reads when configured
// - write data driven from write buffer
// - single or four-word reads into read buffer
// - lanes from size, low address, byte order
// - low address names the expected datum
// - writes/singles: exact address, then increment
// - burst reads count from zero by width
// - low address pins sampled as reset config
// - diagnostic pin: miss phase then I/D phase
// - I/D phase: high instruction, low data
// - latch strobe high while address valid
// - miss shown high during address phase
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "mbi_map.svh"
module mbi_bus_if import mbi_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        bigEndian,
  input  wire logic        holdStrobesOnRead,
  input  wire logic        reqValid,
  input  wire mbi_req_t    req,
  output logic             reqReady,
  output logic [31:0]      rdData,
  output logic [1:0]       rdIndex,
  output logic             rdValid,
  output logic             done,
  output mbi_cfg_t         cfg,
  input  wire logic        datumAck,
  input  wire logic [31:0] adIn,
  output logic [31:0]      adOut,
  output logic             adOe,
  input  wire logic [3:0]  lowAddrIn,
  output logic [3:0]       lowAddrOut,
  output logic             lowAddrOe,
  output logic             diag,
  output logic             addrLatch
);

  ////////////////////////////////////////////////////////////////////////////////
  // reset configuration sampling

  logic [3:0]  cfgSync1;
  logic [3:0]  cfgSync2;
  logic [3:0]  cfgSync3;

  // config pins come from outside; three flops, taken once second and third agree
  always_ff @(posedge clk) begin
    cfgSync1 <= lowAddrIn;
    cfgSync2 <= cfgSync1;
    cfgSync3 <= cfgSync2;
  end

  wire cfgStable = (cfgSync2 == cfgSync3);

  always_ff @(posedge clk) begin
    if (rst && cfgStable) begin
      cfg.bootRom16    <= cfgSync3[`MBI_CFG_BOOT16_BIT];
      cfg.bootRom8     <= cfgSync3[`MBI_CFG_BOOT8_BIT];
      cfg.reserved_high_option <= cfgSync3[`MBI_CFG_RSVD_BIT];
      cfg.extended_address_hold_option  <= cfgSync3[`MBI_CFG_HOLD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transfer state

  mbi_state_t  state;
  mbi_state_t  next_state;
  mbi_req_t    cur;
  logic [3:0]  lowAddr;
  logic [2:0]  pieceLeft;
  logic [1:0]  wordCnt;

  wire idle     = (state == MBI_IDLE);
  wire take     = idle && reqValid;
  wire isPort32 = (cur.port == MBI_PORT32);
  wire isPort16 = (cur.port == MBI_PORT16);

  // step of the low address follows the port width
  wire [3:0] step = isPort32 ? 4'h4 : (isPort16 ? 4'h2 : 4'h1);

  // pieces needed when the datum is wider than the port
  wire [2:0] pieces =
    (cur.burst) ? 3'h1 :
    (cur.size == MBI_SZ_WORD) ? (isPort32 ? 3'h1 : (isPort16 ? 3'h2 : 3'h4)) :
    (cur.size == MBI_SZ_HALF) ? ((isPort32 || isPort16) ? 3'h1 : 3'h2) : 3'h1;

  // burst is four words whatever the port, so piece count per word is set by width
  wire [2:0] perWord = isPort32 ? 3'h1 : (isPort16 ? 3'h2 : 3'h4);
  wire lastPiece = (pieceLeft == 3'h1);
  wire lastWord  = !cur.burst || (wordCnt == 2'h3);

  ////////////////////////////////////////////////////////////////////////////////
  // byte lane selection

  logic [3:0] laneMask;

  always_comb begin
    laneMask = 4'h0;
    case (cur.size)
      MBI_SZ_BYTE: laneMask = 4'h1 << (bigEndian ? ~cur.addr[1:0] : cur.addr[1:0]);
      MBI_SZ_HALF: laneMask = (bigEndian ^ cur.addr[1]) ? 4'hC : 4'h3;
      MBI_SZ_WORD: laneMask = 4'hF;
      default:     laneMask = 4'h0;
    endcase
  end

  // strobes only mean something to 32-bit ports; read masking lets latched strobes be write enables
  wire stbQuiet = !cur.write && holdStrobesOnRead;
  wire [3:0] byteLaneStrobe_n = (stbQuiet || cur.burst) ? `MBI_STRB_IDLE
                                : ~laneMask;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb begin
    next_state = state;
    case (state)
      MBI_IDLE: if (reqValid) next_state = MBI_ADDR;
      MBI_ADDR: next_state = MBI_TURN;
      MBI_TURN: next_state = MBI_DATA;
      MBI_DATA: if (datumAck && lastPiece && lastWord) begin
        next_state = cfg.extended_address_hold_option ? MBI_HOLD : MBI_IDLE;
      end
      MBI_HOLD: next_state = MBI_IDLE;
      default:  next_state = MBI_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= MBI_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (take) begin
      cur       <= req;
    end
  end

  wire [2:0] pieceInit = req.burst ? (req.port == MBI_PORT32 ? 3'h1 :
                         (req.port == MBI_PORT16 ? 3'h2 : 3'h4)) : 3'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      lowAddr   <= 4'h0;
      pieceLeft <= 3'h0;
      wordCnt   <= 2'h0;
    end else if (take) begin
      lowAddr   <= req.burst ? 4'h0 : req.addr[3:0];
      pieceLeft <= pieceInit;
      wordCnt   <= 2'h0;
    end else if (state == MBI_ADDR && pieceLeft == 3'h0) begin
      pieceLeft <= pieces;
    end else if (state == MBI_DATA && datumAck) begin
      lowAddr   <= lowAddr + step;
      if (!lastPiece) begin
        pieceLeft <= pieceLeft - 3'h1;
      end else if (!lastWord) begin
        pieceLeft <= perWord;
        wordCnt   <= wordCnt + 2'h1;
      end
    end
  end

  // strobes for a request taken this cycle are worked out from the incoming fields
  logic [3:0] reqLane;
  always_comb begin
    reqLane = 4'h0;
    case (req.size)
      MBI_SZ_BYTE: reqLane = 4'h1 << (bigEndian ? ~req.addr[1:0] : req.addr[1:0]);
      MBI_SZ_HALF: reqLane = (bigEndian ^ req.addr[1]) ? 4'hC : 4'h3;
      MBI_SZ_WORD: reqLane = 4'hF;
      default:     reqLane = 4'h0;
    endcase
  end

  wire reqQuiet = (!req.write && holdStrobesOnRead) || req.burst;
  wire [3:0] byteLaneStrobeAt = take ? (reqQuiet ? `MBI_STRB_IDLE : ~reqLane)
                                     : byteLaneStrobe_n;

  // pin must name the datum now expected, so it follows the stepped value, not the old one
  wire [3:0] nextLowAddr = (state == MBI_DATA && datumAck) ? lowAddr + step : lowAddr;

  ////////////////////////////////////////////////////////////////////////////////
  // pins and core answers

  always_ff @(posedge clk) begin
    if (rst) begin
      adOut      <= 32'h0;
      adOe       <= 1'b0;
      lowAddrOe  <= 1'b0;
      lowAddrOut <= 4'h0;
      addrLatch  <= 1'b0;
      diag       <= 1'b0;
      reqReady   <= 1'b0;
      rdValid    <= 1'b0;
      rdData     <= 32'h0;
      rdIndex    <= 2'h0;
      done       <= 1'b0;
    end else begin
      reqReady  <= (next_state == MBI_IDLE);
      lowAddrOe <= 1'b1;
      lowAddrOut <= (next_state == MBI_ADDR) ? (req.burst ? 4'h0 : req.addr[3:0]) : nextLowAddr;
      addrLatch <= (next_state == MBI_ADDR);
      rdValid   <= 1'b0;
      done      <= 1'b0;
      case (next_state)
        MBI_ADDR: begin
          adOut <= {take ? req.addr[31:4] : cur.addr[31:4], byteLaneStrobeAt};
          adOe  <= 1'b1;
          diag  <= take ? req.miss : cur.miss;
        end
        MBI_TURN, MBI_DATA: begin
          adOut <= cur.wdata;
          adOe  <= cur.write;
          diag  <= cur.instr;
        end
        default: begin
          adOe  <= 1'b0;
          diag  <= 1'b0;
        end
      endcase
      if (state == MBI_DATA && datumAck && !cur.write) begin
        rdData  <= adIn;
        rdIndex <= wordCnt;
        rdValid <= 1'b1;
      end
      if (state == MBI_DATA && next_state != MBI_DATA) begin
        done <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** tb/mbi_bus_chk_assertions.sv ***
// assertions on the bus interface ports
// assumes a bind to mbi_bus_if
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
module mbi_bus_chk import mbi_pkg::*; (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        holdStrobesOnRead,
  input wire logic        reqValid,
  input wire mbi_req_t    req,
  input wire logic        reqReady,
  input wire logic [31:0] adOut,
  input wire logic        adOe,
  input wire logic [3:0]  lowAddrOut,
  input wire logic        diag,
  input wire logic        addrLatch
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  take_latch_a: assert property (reqValid && reqReady |=> addrLatch && !reqReady)
    else $error("no address phase");
  latch_short_a: assert property (addrLatch |=> !addrLatch)
    else $error("latch strobe too long");
  high_addr_a: assert property (addrLatch |-> adOe && adOut[31:4] == $past(req.addr[31:4]))
    else $error("bad high address");
  read_hold_a: assert property (addrLatch && !$past(req.write) && $past(holdStrobesOnRead)
    |-> adOut[3:0] == 4'hF) else $error("strobes active on read");
  miss_phase_a: assert property (addrLatch |-> diag == $past(req.miss))
    else $error("bad miss flag");
  instr_phase_a: assert property ($past(addrLatch) && !$past(req.write, 2)
    |-> diag == $past(req.instr, 2)) else $error("bad fetch kind");
  data_phase_a: assert property ($past(addrLatch) |-> !addrLatch && adOe == $past(req.write, 2)
    && (!adOe || adOut == $past(req.wdata, 2))) else $error("bad data phase");
  low_start_a: assert property (addrLatch
    |-> lowAddrOut == ($past(req.burst) ? 4'h0 : $past(req.addr[3:0])))
    else $error("bad first low address");
  cover property (addrLatch && $past(req.burst));
  cover property (addrLatch && !$past(req.write));
  cover property ($past(addrLatch) && adOe);
endmodule
bind mbi_bus_if mbi_bus_chk mbi_bus_chk_i (.clk(clk), .rst(rst),
  .holdStrobesOnRead(holdStrobesOnRead), .reqValid(reqValid), .req(req), .reqReady(reqReady),
  .adOut(adOut), .adOe(adOe), .lowAddrOut(lowAddrOut), .diag(diag), .addrLatch(addrLatch));
`default_nettype wire

// *** tb/mbi_mem_model.sv ***
// memory model: acks each datum and returns a pattern
// assumes the interface drives addrLatch, adOe and done
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
module mbi_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        adOe,
  input  wire logic [31:0] adOut,
  input  wire logic [3:0]  lowAddrOut,
  input  wire logic        addrLatch,
  input  wire logic        done,
  output logic             datumAck,
  output logic [31:0]      adIn
);
  logic act;
  logic tick;
  always_ff @(posedge clk) begin
    tick <= rst ? 1'b0 : ~tick;
    if (rst || done) act <= 1'b0;
    else if (addrLatch) act <= 1'b1;
  end
  assign datumAck = act && (!slow || tick);
  // idle lines toggle so a stale value cannot pass
  assign adIn = adOe ? adOut : act ? {28'hA5A5C3C, lowAddrOut} : {32{tick}};
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the bus interface
// assumes mbi_bus_if, its checker and the memory model
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
module tb import mbi_pkg::*;;
  logic        clk, rst, bigEndian, holdStrobesOnRead, reqValid, reqReady, rdValid;
  logic        done, datumAck, adOe, lowAddrOe, diag, addrLatch, slow;
  logic [31:0] rdData, adIn, adOut;
  logic [3:0]  lowAddrIn, lowAddrOut;
  logic [1:0]  rdIndex;
  mbi_req_t    req;
  mbi_cfg_t    cfg;
  int          fail_count, checked;
  assign lowAddrIn = lowAddrOe ? lowAddrOut : 4'hA;
  mbi_bus_if mbi_bus_if_i (.clk(clk), .rst(rst), .bigEndian(bigEndian),
    .holdStrobesOnRead(holdStrobesOnRead), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .rdData(rdData), .rdIndex(rdIndex), .rdValid(rdValid), .done(done), .cfg(cfg),
    .datumAck(datumAck), .adIn(adIn), .adOut(adOut), .adOe(adOe), .lowAddrIn(lowAddrIn),
    .lowAddrOut(lowAddrOut), .lowAddrOe(lowAddrOe), .diag(diag), .addrLatch(addrLatch));
  mbi_mem_model mbi_mem_model_i (.clk(clk), .rst(rst), .slow(slow), .adOe(adOe),
    .adOut(adOut), .lowAddrOut(lowAddrOut), .addrLatch(addrLatch), .done(done),
    .datumAck(datumAck), .adIn(adIn));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic xfer(input logic [31:0] a, input logic [1:0] sz, input logic [1:0] pt,
                      input logic wr, input logic bu, input logic be, input logic hs);
    int k, i, nrd, pb, np, pw;
    logic [3:0] st;
    logic tmo;
    pb = 4 >> pt;
    pw = 4 / pb;
    np = bu ? 16 / pb : (sz + 1 > pb ? (sz + 1) / pb : 1);
    st = sz == 2'h3 ? 4'h0 : sz == 2'h1 ? (a[1] ^ be ? 4'h3 : 4'hC) : ~(4'h1 << (a[1:0] ^ {2{be}}));
    if (bu || (!wr && hs)) st = 4'hF;
    i = 0;
    nrd = 0;
    k = 0;
    @(posedge clk);
    req <= '{a, ~a, mbi_size_t'(sz), mbi_port_t'(pt), wr, bu, a[4], a[5]};
    bigEndian <= be;
    holdStrobesOnRead <= hs;
    reqValid <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (!reqReady && k < 50);
    tmo = !reqReady;
    reqValid <= 1'b0;
    for (k = 0; k < 200; k++) begin
      #1;
      if (k == 0 && (pt == 2'h0 || st == 4'hF)) check("strobes", adOut[3:0], st);
      if (rdValid && bu) check("index", rdIndex, nrd / pw);
      if (rdValid && bu) nrd++;
      if (rdValid && !bu && pt == 2'h0) check("rdata", rdData, {28'hA5A5C3C, a[3:0]});
      if (done) break;
      if (k > 1 && datumAck) check("lowAddr", lowAddrOut, (bu ? 0 : a[3:0]) + i * pb);
      if (k > 1 && datumAck) i++;
      @(posedge clk);
    end
    if (k == 200 || tmo) begin
      fail_count++;
      conclude();
    end
    check("pieces", i, np);
    if (bu) check("words", nrd, 4 * pw);
    $display("test done addr %h size %0d port %0d", a, sz, pt);
  endtask
  initial begin
    rst = 1'b1;
    reqValid = 1'b0;
    req = '0;
    bigEndian = 1'b0;
    holdStrobesOnRead = 1'b0;
    slow = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    check("cfgOe", lowAddrOe, 0);
    rst <= 1'b0;
    @(posedge clk);
    #1 check("cfg", cfg, 4'h5);
    for (int n = 0; n < 4; n++) xfer(32'h40 + n, 2'h0, 2'h0, 1, 0, n[1], 0);
    for (int n = 0; n < 2; n++) xfer(32'h42, 2'h1, 2'h0, 1, 0, n[0], 0);
    xfer(32'h8, 2'h3, 2'h0, 1, 0, 0, 1);
    xfer(32'h34, 2'h3, 2'h0, 0, 0, 0, 1);
    xfer(32'h14, 2'h3, 2'h0, 0, 0, 0, 0);
    for (int n = 0; n < 3; n++) begin
      slow <= n[0];
      xfer(32'h20, 2'h3, n[1:0], 0, 1, 0, 0);
    end
    xfer(32'h4, 2'h3, 2'h2, 1, 0, 0, 0);
    xfer(32'h16, 2'h1, 2'h1, 0, 0, 1, 0);
    conclude();
  end
endmodule
`default_nettype wire
